// ===== rtl/def_time_stage.sv
// Purpose: One definite-time stage: comparison, start, operate timer, trip.
// Assumes: tick is a one-cycle pulse every TICK_MS.
// Notes:   over_mode picks direction; hold_en gives the release hold.
module def_time_stage
    import vprot_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              tick,
    input  wire logic              over_mode,
    input  wire logic              hold_en,
    input  wire logic              block,
    input  wire logic [MAG_W-1:0]  meas,
    input  wire logic [MAG_W-1:0]  thr,
    input  wire logic [PCT_W-1:0]  hyst,
    input  wire logic [TIME_W-1:0] op_time,
    input  wire logic [TIME_W-1:0] hold_time,
    output logic                   start,
    output logic                   trip,
    output logic [TIME_W-1:0]      timer
);

    logic [TIME_W-1:0] hold_cnt;
    logic [TIME_W-1:0] next_hold_cnt;
    logic [TIME_W-1:0] next_timer;
    logic              next_start;
    logic              next_trip;
    logic              pick_on;
    logic              pick_off;
    logic [MAG_W:0]    meas_w;
    logic [MAG_W:0]    band;

    always_comb
    begin
        meas_w   = {1'b0, meas};
        band     = {1'b0, thr} + {5'h00, hyst};
        pick_on  = over_mode ? (meas > thr) : (meas < thr);
        // Deadband only widens the release side
        pick_off = over_mode ? (meas_w + {5'h00, hyst} <= {1'b0, thr})
                             : (meas_w >= band);
        next_start    = start;
        next_timer    = timer;
        next_hold_cnt = hold_cnt;
        if (tick)
        begin
            // Start moves only on the tick unless block clears it: fixed delay
            if (!start && pick_on)
                next_start = 1'b1;
            else if (start && pick_off)
                next_start = 1'b0;
            if (start)
            begin
                next_hold_cnt = '0;
                if (timer < op_time)
                    next_timer = timer + 15'h0001;
            end
            else if (hold_en && timer != '0)
            begin
                if (hold_cnt >= hold_time)
                begin
                    next_timer    = '0;
                    next_hold_cnt = '0;
                end
                else
                    next_hold_cnt = hold_cnt + 15'h0001;
            end
            else
                next_timer = '0;
        end
        next_trip = next_start && (next_timer >= op_time);
        if (block)
        begin
            next_start    = 1'b0;
            next_trip     = 1'b0;
            next_timer    = '0;
            next_hold_cnt = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            start    <= 1'b0;
            trip     <= 1'b0;
            timer    <= '0;
            hold_cnt <= '0;
        end
        else
        begin
            start    <= next_start;
            trip     <= next_trip;
            timer    <= next_timer;
            hold_cnt <= next_hold_cnt;
        end
    end

endmodule

// ===== rtl/voltage_protection_stages.sv
// Purpose: Three overvoltage and three undervoltage definite-time stages.
// Assumes: volt_mag is the fundamental magnitude in 0.1 % of nominal.
// Notes:   Stages 0..2 are overvoltage, 3..5 undervoltage.
module voltage_protection_stages
    import vprot_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic [MAG_W-1:0]        volt_mag,
    input  wire logic                    ext_block,
    input  wire logic [2:0]              int_block_src,
    input  wire logic [1:0]              int_block_sel,
    input  wire logic                    cfg_load,
    input  wire logic [2:0]              cfg_stage,
    input  wire logic [PCT_W-1:0]        cfg_threshold,
    input  wire logic [TIME_W-1:0]       cfg_op_time,
    input  wire logic [PCT_W-1:0]        cfg_hysteresis,
    input  wire logic [TIME_W-1:0]       cfg_hold_time,
    input  wire logic [3:0]              cfg_event_en,
    input  wire logic                    cfg_self_load,
    input  wire logic [PCT_W-1:0]        cfg_self_level,
    input  wire logic                    counters_clear,
    output logic [NSTAGE-1:0]            start,
    output logic [NSTAGE-1:0]            trip,
    output logic                         uv_blocked,
    output logic [NSTAGE-1:0][CNT_W-1:0] start_count,
    output logic [NSTAGE-1:0][CNT_W-1:0] trip_count,
    output logic [NSTAGE-1:0][MAG_W-1:0] fault_value,
    output logic [NSTAGE-1:0][RATIO_W-1:0] elapsed_ratio,
    output logic [NSTAGE-1:0]            event_start_on,
    output logic [NSTAGE-1:0]            event_start_off,
    output logic [NSTAGE-1:0]            event_trip_on,
    output logic [NSTAGE-1:0]            event_trip_off
);

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    logic [31:0] div_cnt;
    logic [31:0] next_div_cnt;
    logic        tick;
    logic        next_tick;

    always_comb
    begin
        next_tick    = 1'b0;
        next_div_cnt = div_cnt + 32'h00000001;
        if (div_cnt >= 32'(TICK_CYCLES - 1))
        begin
            next_div_cnt = '0;
            next_tick    = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            tick    <= next_tick;
        end
    end

    // ----------------------------------------------------------------
    // Measurement and undervoltage blocking
    // ----------------------------------------------------------------
    logic [MAG_W-1:0] meas;
    logic [PCT_W-1:0] self_lvl;
    logic [PCT_W-1:0] next_self_lvl;
    logic             next_uv_blocked;
    logic             int_block;

    always_comb
    begin
        next_self_lvl = cfg_self_load ? cfg_self_level : self_lvl;
        int_block     = 1'b0;
        if (int_block_sel != 2'h0)
            int_block = int_block_src[int_block_sel - 2'h1];
        next_uv_blocked = ext_block
            || int_block
            // Under symmetry one magnitude speaks for every phase
            || (meas < MAG_W'(self_lvl) * PCT_SCALE);
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            meas       <= '0;
            self_lvl   <= SELF_BLK_DEF;
            uv_blocked <= 1'b0;
        end
        else
        begin
            meas       <= volt_mag;
            self_lvl   <= next_self_lvl;
            uv_blocked <= next_uv_blocked;
        end
    end

    // ----------------------------------------------------------------
    // First-stage extras: deadband and release hold
    // ----------------------------------------------------------------
    logic [1:0][PCT_W-1:0]  hyst;
    logic [1:0][PCT_W-1:0]  next_hyst;
    logic [1:0][TIME_W-1:0] hold;
    logic [1:0][TIME_W-1:0] next_hold;

    always_comb
    begin
        next_hyst = hyst;
        next_hold = hold;
        if (cfg_load && (cfg_stage == 3'h0 || cfg_stage == 3'h3))
        begin
            next_hyst[cfg_stage[1]] = cfg_hysteresis;
            next_hold[cfg_stage[1]] = cfg_hold_time;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            hyst <= {2{HYST_DEF}};
            hold <= {2{HOLD_DEF}};
        end
        else
        begin
            hyst <= next_hyst;
            hold <= next_hold;
        end
    end

    // ----------------------------------------------------------------
    // Stages
    // ----------------------------------------------------------------
    logic [NSTAGE-1:0][TIME_W-1:0] timer;
    logic [NSTAGE-1:0][PCT_W-1:0]  thr;
    logic [NSTAGE-1:0][TIME_W-1:0] op_time;
    logic [NSTAGE-1:0][3:0]        ev_en;
    logic [NSTAGE-1:0]             start_q;
    logic [NSTAGE-1:0]             trip_q;

    for (genvar i = 0; i < NSTAGE; i++)
    begin : g_stage
        localparam bit OVER  = (i < 3);
        localparam bit FIRST = (i % 3 == 0);
        localparam int H     = i / 3;
        localparam logic [PCT_W-1:0] THR_RST = (i == 0) ? OV1_THR_DEF
            : (i < 3) ? OV23_THR_DEF
            : (i == 3) ? UV1_THR_DEF : UV23_THR_DEF;
        localparam logic [TIME_W-1:0] OP_RST = (i == 0) ? OV1_OP_DEF
            : (i < 3) ? OV23_OP_DEF
            : (i == 3) ? UV1_OP_DEF : UV23_OP_DEF;

        logic [PCT_W-1:0]   next_thr;
        logic [TIME_W-1:0]  next_op;
        logic [3:0]         next_ev_en;
        logic [CNT_W-1:0]   next_sc;
        logic [CNT_W-1:0]   next_tc;
        logic [MAG_W-1:0]   next_fault;
        logic [RATIO_W-1:0] next_ratio;
        logic [21:0]        scaled;
        logic [3:0]         next_ev;
        logic               s_rise;
        logic               t_rise;

        // Each stage owns its own settings
        always_comb
        begin
            next_thr   = thr[i];
            next_op    = op_time[i];
            next_ev_en = ev_en[i];
            if (cfg_load && cfg_stage == 3'(i))
            begin
                next_thr   = cfg_threshold;
                next_op    = cfg_op_time;
                next_ev_en = cfg_event_en;
            end
        end

        def_time_stage u_stage (
            .clock     (clock),
            .rst_n     (rst_n),
            .tick      (tick),
            .over_mode (OVER),
            .hold_en   (FIRST),
            .block     (OVER ? 1'b0 : uv_blocked),
            .meas      (meas),
            .thr       (MAG_W'(thr[i]) * PCT_SCALE),
            .hyst      (FIRST ? hyst[H] : 8'h00),
            .op_time   (op_time[i]),
            .hold_time (hold[H]),
            .start     (start[i]),
            .trip      (trip[i]),
            .timer     (timer[i])
        );

        // Recording: counters, extreme value, elapsed ratio, events
        always_comb
        begin
            s_rise  = start[i] && !start_q[i];
            t_rise  = trip[i] && !trip_q[i];
            next_sc = counters_clear ? '0 : start_count[i];
            next_tc = counters_clear ? '0 : trip_count[i];
            // Clear applies first; a same-cycle rise then counts from zero unless the old count was full
            if (s_rise && start_count[i] != '1)
                next_sc = next_sc + 16'h0001;
            if (t_rise && trip_count[i] != '1)
                next_tc = next_tc + 16'h0001;
            next_fault = fault_value[i];
            if (s_rise)
                next_fault = meas;
            else if (start[i] && (OVER ? meas > fault_value[i]
                                       : meas < fault_value[i]))
                next_fault = meas;
            // Divide by zero guarded: zero operate time reads full
            scaled     = 22'(timer[i]) * 22'h000064;
            next_ratio = elapsed_ratio[i];
            if (trip[i] || op_time[i] == '0)
                next_ratio = RATIO_FULL;
            else if (start[i])
                next_ratio = 7'(scaled / 22'(op_time[i]));
            next_ev[0] = ev_en[i][0] && s_rise;
            next_ev[1] = ev_en[i][1] && !start[i] && start_q[i];
            next_ev[2] = ev_en[i][2] && t_rise;
            next_ev[3] = ev_en[i][3] && !trip[i] && trip_q[i];
        end

        always_ff @(posedge clock)
        begin
            if (!rst_n)
            begin
                thr[i]             <= THR_RST;
                op_time[i]         <= OP_RST;
                ev_en[i]           <= EVENT_EN_DEF;
                start_q[i]         <= 1'b0;
                trip_q[i]          <= 1'b0;
                start_count[i]     <= '0;
                trip_count[i]      <= '0;
                fault_value[i]     <= '0;
                elapsed_ratio[i]   <= '0;
                event_start_on[i]  <= 1'b0;
                event_start_off[i] <= 1'b0;
                event_trip_on[i]   <= 1'b0;
                event_trip_off[i]  <= 1'b0;
            end
            else
            begin
                thr[i]             <= next_thr;
                op_time[i]         <= next_op;
                ev_en[i]           <= next_ev_en;
                start_q[i]         <= start[i];
                trip_q[i]          <= trip[i];
                start_count[i]     <= next_sc;
                trip_count[i]      <= next_tc;
                fault_value[i]     <= next_fault;
                elapsed_ratio[i]   <= next_ratio;
                event_start_on[i]  <= next_ev[0];
                event_start_off[i] <= next_ev[1];
                event_trip_on[i]   <= next_ev[2];
                event_trip_off[i]  <= next_ev[3];
            end
        end

        // ------------------------------------------------------------
        // Checks
        // ------------------------------------------------------------
        trip_needs_start_a: assert property (
            @(posedge clock) disable iff (!rst_n)
            trip[i] |-> start[i] && timer[i] >= op_time[i])
            else $error("trip without start or timer short");

        start_on_tick_a: assert property (
            @(posedge clock) disable iff (!rst_n)
            !tick && !(uv_blocked && !OVER) |=> $stable(start[i]))
            else $error("start moved off the tick");

        ratio_full_a: assert property (
            @(posedge clock) disable iff (!rst_n)
            $rose(trip[i]) |=> elapsed_ratio[i] == RATIO_FULL)
            else $error("elapsed ratio not full after trip");

        start_count_a: assert property (
            @(posedge clock) disable iff (!rst_n)
            $rose(start[i]) && !counters_clear && start_count[i] != '1
            |=> start_count[i] == $past(start_count[i]) + 16'h0001)
            else $error("start count did not advance");

        event_gate_a: assert property (
            @(posedge clock) disable iff (!rst_n)
            event_start_on[i] |-> $past(ev_en[i][0])
                && $past(start[i]) && !$past(start[i], 2))
            else $error("start event without enabled edge");

        if (OVER && !FIRST)
        begin : g_ov_chk
            ov_pickup_a: assert property (
                @(posedge clock) disable iff (!rst_n)
                tick && meas > MAG_W'(thr[i]) * PCT_SCALE |=> start[i])
                else $error("overvoltage start missed");
        end

        if (!OVER && !FIRST)
        begin : g_uv_chk
            uv_pickup_a: assert property (
                @(posedge clock) disable iff (!rst_n)
                tick && !uv_blocked
                && meas < MAG_W'(thr[i]) * PCT_SCALE |=> start[i])
                else $error("undervoltage start missed");
        end

        if (FIRST)
        begin : g_hold_chk
            hold_resume_a: assert property (
                @(posedge clock) disable iff (!rst_n)
                $rose(start[i]) |-> timer[i] == $past(timer[i]))
                else $error("held timer lost on fault return");
        end
    end

    uv_block_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        uv_blocked |=> start[5:3] == 3'h0 && trip[5:3] == 3'h0)
        else $error("undervoltage stage active while blocked");

    self_block_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        meas < MAG_W'(self_lvl) * PCT_SCALE && !cfg_self_load
        |=> uv_blocked ##1 start[5:3] == 3'h0)
        else $error("self-block level not honoured");

endmodule

// ===== rtl/vprot_pkg.sv
// Purpose: Shared constants for the definite-time voltage stages.
// Assumes: 125 MHz clock; magnitudes in 0.1 % of nominal voltage.
// Notes:   Times are held in ticks of TICK_MS milliseconds.
package vprot_pkg;

    localparam int NSTAGE  = 6;
    localparam int MAG_W   = 12;
    localparam int TIME_W  = 15;
    localparam int CNT_W   = 16;
    localparam int PCT_W   = 8;
    localparam int RATIO_W = 7;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLOCK_MHZ       = 125;
    localparam int TICK_MS         = 10;
    localparam int TICK_CYCLES_DEF = TICK_MS * 1000 * CLOCK_MHZ;

    localparam logic [MAG_W-1:0]   PCT_SCALE  = 12'h00A;
    localparam logic [RATIO_W-1:0] RATIO_FULL = 7'h64;

    // ----------------------------------------------------------------
    // Reset settings
    // ----------------------------------------------------------------
    localparam logic [PCT_W-1:0] OV1_THR_DEF  = 8'h78;
    localparam logic [PCT_W-1:0] OV23_THR_DEF = 8'h82;
    localparam logic [PCT_W-1:0] UV1_THR_DEF  = 8'h50;
    localparam logic [PCT_W-1:0] UV23_THR_DEF = 8'h46;
    localparam logic [PCT_W-1:0] SELF_BLK_DEF = 8'h0A;
    localparam logic [PCT_W-1:0] HYST_DEF     = 8'h05;

    localparam int OV1_OP_MS  = 200;
    localparam int OV23_OP_MS = 100;
    localparam int UV1_OP_MS  = 20000;
    localparam int UV23_OP_MS = 2000;
    localparam int HOLD_MS    = 60;

    localparam logic [TIME_W-1:0] OV1_OP_DEF  = TIME_W'(OV1_OP_MS / TICK_MS);
    localparam logic [TIME_W-1:0] OV23_OP_DEF = TIME_W'(OV23_OP_MS / TICK_MS);
    localparam logic [TIME_W-1:0] UV1_OP_DEF  = TIME_W'(UV1_OP_MS / TICK_MS);
    localparam logic [TIME_W-1:0] UV23_OP_DEF = TIME_W'(UV23_OP_MS / TICK_MS);
    localparam logic [TIME_W-1:0] HOLD_DEF    = TIME_W'(HOLD_MS / TICK_MS);

    localparam logic [3:0] EVENT_EN_DEF = 4'hF;

endpackage

// ===== sim/meas_front.sv
// Purpose: Measurement front end feeding the stage block.
// Assumes: One fundamental magnitude in 0.1 % of nominal.
// Notes:   Delivers the requested level one clock later.
module meas_front
    import vprot_pkg::*;
(
    input  wire logic [MAG_W-1:0] level,
    input  wire logic             clock,
    output logic      [MAG_W-1:0] volt_mag
);
    timeunit 1ns;
    timeprecision 1ps;

    // Nominal until the first edge so the block never sees unknowns
    initial volt_mag = 12'h3E8;

    always @(posedge clock)
    begin
        volt_mag <= level;
    end
endmodule

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the voltage stages.
// Assumes: Short tick of TC clocks instead of 10 ms.
// Notes:   Stage 1 over, stage 4 under, stage 0 release hold.
module tb_top
    import vprot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TC    = 4;
    localparam int LIMIT = 20000;

    logic clock, rst_n, ext_block, cfg_load, cfg_self_load, counters_clear;
    logic uv_blocked;
    logic [MAG_W-1:0]  level, volt_mag;
    logic [2:0]        int_block_src, cfg_stage;
    logic [1:0]        int_block_sel;
    logic [PCT_W-1:0]  cfg_threshold, cfg_hysteresis, cfg_self_level;
    logic [TIME_W-1:0] cfg_op_time, cfg_hold_time;
    logic [3:0]        cfg_event_en;
    logic [NSTAGE-1:0] start, trip, ev_s_on, ev_s_off, ev_t_on, ev_t_off;
    logic [NSTAGE-1:0][CNT_W-1:0]   start_count, trip_count;
    logic [NSTAGE-1:0][MAG_W-1:0]   fault_value;
    logic [NSTAGE-1:0][RATIO_W-1:0] elapsed_ratio;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;

    meas_front FE (.level(level), .clock(clock), .volt_mag(volt_mag));

    voltage_protection_stages #(.TICK_CYCLES(TC)) DUT (
        .clock(clock), .rst_n(rst_n), .volt_mag(volt_mag),
        .ext_block(ext_block), .int_block_src(int_block_src),
        .int_block_sel(int_block_sel), .cfg_load(cfg_load),
        .cfg_stage(cfg_stage), .cfg_threshold(cfg_threshold),
        .cfg_op_time(cfg_op_time), .cfg_hysteresis(cfg_hysteresis),
        .cfg_hold_time(cfg_hold_time), .cfg_event_en(cfg_event_en),
        .cfg_self_load(cfg_self_load), .cfg_self_level(cfg_self_level),
        .counters_clear(counters_clear), .start(start), .trip(trip),
        .uv_blocked(uv_blocked), .start_count(start_count),
        .trip_count(trip_count), .fault_value(fault_value),
        .elapsed_ratio(elapsed_ratio), .event_start_on(ev_s_on),
        .event_start_off(ev_s_off), .event_trip_on(ev_t_on),
        .event_trip_off(ev_t_off));

    // ----------------------------------------------------------------
    // Clock, timeout, reporting
    // ----------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            bad_count++;
            $display("ERROR %0t run did not finish", $time);
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    function automatic logic pick(input int kind, input int idx);
        if (kind == 0)
            return start[idx];
        if (kind == 1)
            return trip[idx];
        return uv_blocked;
    endfunction

    // Bounded wait; n counts the clocks spent
    task automatic wait_sig(input int kind, input int idx, input logic val,
                            output int n);
        n = 0;
        while (pick(kind, idx) !== val && n < 200)
        begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask

    task automatic cfg(input logic [2:0] stg, input logic [7:0] thr,
                       input logic [14:0] op, input logic [14:0] hold);
        @(posedge clock);
        cfg_load <= 1'b1;
        cfg_stage <= stg;
        cfg_threshold <= thr;
        cfg_op_time <= op;
        cfg_hold_time <= hold;
        @(posedge clock);
        cfg_load <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_ov_trip;
        int n;
        check(start === 6'h00 && trip === 6'h00, "outputs after reset");
        cfg(3'h1, 8'h8C, 15'h0002, 15'h0000);
        @(posedge clock);
        level <= 12'h5DC;
        wait_sig(0, 1, 1'b1, n);
        check(start[1] === 1'b1, "over start missing");
        @(posedge clock);
        #1;
        check(ev_s_on[1] === 1'b1, "start event missing");
        wait_sig(1, 1, 1'b1, n);
        check(trip[1] === 1'b1 && n >= 7 && n <= 8, "over trip time");
        @(posedge clock);
        #1;
        check(trip_count[1] === 16'h0001, "trip count");
        check(elapsed_ratio[1] === RATIO_FULL, "ratio at trip");
        check(fault_value[1] === 12'h5DC, "peak fault value");
        @(posedge clock);
        level <= 12'h3E8;
        wait_sig(0, 1, 1'b0, n);
        check(trip[1] === 1'b0 && n < 12, "trip outlived start");
        @(posedge clock);
        counters_clear <= 1'b1;
        #1;
        check(ev_s_off[1] === 1'b1 && ev_t_off[1] === 1'b1, "off events");
        @(posedge clock);
        counters_clear <= 1'b0;
        #1;
        check(start_count[1] === 16'h0000, "count not cleared");
    endtask

    task automatic s_uv;
        int n;
        cfg(3'h4, 8'h46, 15'h0001, 15'h0000);
        @(posedge clock);
        level <= 12'h258;
        wait_sig(0, 4, 1'b1, n);
        check(start[4] === 1'b1, "under start missing");
        wait_sig(1, 4, 1'b1, n);
        check(trip[4] === 1'b1 && n <= 5, "under trip time");
        @(posedge clock);
        ext_block <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check(uv_blocked === 1'b1 && start[5:3] === 3'h0, "ext blk");
        @(posedge clock);
        ext_block <= 1'b0;
        level <= 12'h3E8;
        repeat (12) @(posedge clock);
    endtask

    task automatic s_block;
        int n;
        int_block_sel <= 2'h2;
        int_block_src <= 3'h2;
        wait_sig(2, 0, 1'b1, n);
        check(n <= 3, "internal block late");
        @(posedge clock);
        int_block_src <= 3'h5;
        wait_sig(2, 0, 1'b0, n);
        check(uv_blocked === 1'b0 && n <= 3, "wrong source taken");
        @(posedge clock);
        int_block_sel <= 2'h0;
        level <= 12'h032;
        wait_sig(2, 0, 1'b1, n);
        check(n <= 4, "self block late");
        repeat (12) @(posedge clock);
        #1;
        check(start[5:3] === 3'h0, "start while self blocked");
        level <= 12'h3E8;
        repeat (12) @(posedge clock);
    endtask

    // Fresh timer would need 16 clocks; held value must shorten it
    task automatic s_hold;
        int n;
        cfg(3'h0, 8'h8C, 15'h0004, 15'h0014);
        @(posedge clock);
        level <= 12'h5DC;
        wait_sig(0, 0, 1'b1, n);
        repeat (4) @(posedge clock);
        level <= 12'h3E8;
        wait_sig(0, 0, 1'b0, n);
        check(trip[0] === 1'b0, "trip on short fault");
        repeat (8) @(posedge clock);
        level <= 12'h5DC;
        wait_sig(0, 0, 1'b1, n);
        wait_sig(1, 0, 1'b1, n);
        check(trip[0] === 1'b1 && n <= 13, "held time lost");
    endtask

    // Stage one trip as alarm, stage two trip as the real trip
    task automatic s_alarm;
        int n;
        @(posedge clock);
        level <= 12'h3E8;
        repeat (12) @(posedge clock);
        cfg(3'h0, 8'h78, 15'h0002, 15'h0000);
        cfg(3'h1, 8'h8C, 15'h0006, 15'h0000);
        repeat (12) @(posedge clock);
        #1;
        check(trip[1:0] === 2'h0, "alarm stages not idle");
        @(posedge clock);
        level <= 12'h5DC;
        wait_sig(1, 0, 1'b1, n);
        check(trip[0] === 1'b1 && trip[1] === 1'b0, "alarm not first");
        wait_sig(1, 1, 1'b1, n);
        check(trip[1] === 1'b1, "trip after alarm missing");
    endtask

    initial
    begin
        rst_n = 1'b0;
        level = 12'h3E8;
        {ext_block, cfg_load, cfg_self_load, counters_clear} = 4'h0;
        {int_block_src, int_block_sel, cfg_stage} = 8'h00;
        {cfg_threshold, cfg_op_time, cfg_hold_time} = 38'h0;
        cfg_hysteresis = 8'h00;
        cfg_event_en = 4'hF;
        cfg_self_level = 8'h0A;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
        s_ov_trip();
        s_uv();
        s_block();
        s_hold();
        s_alarm();
        wrap_up();
    end
endmodule
